// ---- sss_params.svh ----
`ifndef SSS_PARAMS_SVH
`define SSS_PARAMS_SVH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SSS_A_CTRL      4'h0
`define SSS_A_FSEL      4'h1
`define SSS_A_FLC       4'h2
`define SSS_A_PROF      4'h3
`define SSS_A_RAMP      4'h4
`define SSS_A_CLIM      4'h5
`define SSS_A_STATUS    4'h6
`define SSS_A_IRQ_STAT  4'h7
`define SSS_A_IRQ_MASK  4'h8
`define SSS_A_CURRENT   4'h9
`define SSS_A_DISPLAY   4'ha
`define SSS_A_STOPLVL   4'hb
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SSS_FSEL_RST    3'h7
`define SSS_FLC_RST     16'h0000
`define SSS_PROF_RST    4'h1
`define SSS_RAMP_RST    8'h0a
`define SSS_CLIM_RST    12'h15e
`define SSS_STOPLVL_RST 16'h0000
`define SSS_CTRL_RST    3'h2
// ----------------------------------------------------------------
// field positions and encodings
// ----------------------------------------------------------------
`define SSS_CTRL_SSTOP  0
`define SSS_CTRL_PLEN   1
`define SSS_CTRL_REMOTE 2
`define SSS_FSEL_RESET  2
`define SSS_JOG_JOG     2'h0
`define SSS_JOG_REMLOC  2'h1
`define SSS_JOG_LKNO    2'h2
`define SSS_JOG_LKNC    2'h3
`define SSS_DISP_IDLE   16'h0000
`define SSS_IRQ_W       4
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SSS_CLK_HZ      50000000
`define SSS_PL_DELAY_S  3
`define SSS_PL_PCT      20
`define SSS_PCT_FULL    100
`endif

// ---- sss_pkg.sv ----
package sss_pkg;
	typedef enum logic [2:0] {
		SSS_IDLE,
		SSS_ACCEL,
		SSS_RUN,
		SSS_DECEL,
		SSS_FAULT
	} sss_state_t;

	// terminal or remote command set
	typedef struct packed {
		logic run;
		logic stop;
		logic ramp2;
		logic jog;
	} sss_cmd_t;

	// indicator and contactor outputs
	typedef struct packed {
		logic power_on;
		logic at_speed;
		logic bypass;
		logic output_on;
		logic fault;
	} sss_ind_t;
endpackage

// ---- sss_sequencer.sv ----
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
`include "sss_params.svh"

module sss_sequencer #(
	parameter int PL_CYCLES = `SSS_PL_DELAY_S * `SSS_CLK_HZ
) (
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             nrst,
	// register port
	input  wire logic [3:0]       addr,
	input  wire logic [15:0]      wdata,
	input  wire logic             wr,
	input  wire logic             rd,
	output logic [15:0]           rdata,
	// terminal strip pins, asynchronous
	input  wire sss_pkg::sss_cmd_t term_cmd,
	// communications adapter commands, same clock
	input  wire sss_pkg::sss_cmd_t comm_cmd,
	// measurement front end, same clock
	input  wire logic [15:0]      phase_a_current,
	input  wire logic             full_speed,
	input  wire logic             line_power,
	// outputs
	output sss_pkg::sss_ind_t     ind,
	output logic                  ramp2_active,
	output logic [15:0]           display,
	output logic                  irq
);
	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	sss_pkg::sss_state_t  state_r;
	sss_pkg::sss_state_t  state_nxt;
	sss_pkg::sss_cmd_t    term_s1_r;
	sss_pkg::sss_cmd_t    term_s2_r;
	sss_pkg::sss_cmd_t    cmd;
	logic [2:0]           fsel_r;
	logic [15:0]          flc_r;
	logic [3:0]           prof_r;
	logic [7:0]           ramp_r;
	logic [11:0]          clim_r;
	logic [15:0]          stoplvl_r;
	logic [2:0]           ctrl_r;
	logic [`SSS_IRQ_W-1:0] irq_stat_r;
	logic [`SSS_IRQ_W-1:0] irq_mask_r;
	logic [`SSS_IRQ_W-1:0] irq_ev;
	logic [31:0]          pl_cnt_r;
	logic                 pl_trip;
	logic                 low_current;
	logic [1:0]           jog_mode;
	logic                 is_remote;
	logic                 lockout;
	logic                 fault_reset;
	logic                 start_ok;
	logic                 run_req;
	logic [31:0]          cur_scaled;
	logic [31:0]          lim_scaled;
	sss_pkg::sss_state_t  state_d_r;

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	// two flops on the terminal pins
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			term_s1_r <= '0;
			term_s2_r <= '0;
		end else begin
			term_s1_r <= term_cmd;
			term_s2_r <= term_s1_r;
		end
	end

	// ----------------------------------------------------------------
	// input function decode
	// ----------------------------------------------------------------
	// selects 4 to 7 turn the second-ramp input into a fault reset, so the
	// ramp-two group is only live for selects 0 to 3
	// jog meaning from the low two bits of the select
	assign jog_mode    = fsel_r[1:0];
	assign is_remote   = (jog_mode == `SSS_JOG_REMLOC) && term_s2_r.jog;
	assign cmd         = is_remote ? comm_cmd : term_s2_r;
	// lockout inputs always come from the terminal strip
	assign lockout     = ((jog_mode == `SSS_JOG_LKNO) && term_s2_r.jog) ||
	                     ((jog_mode == `SSS_JOG_LKNC) && !term_s2_r.jog);
	assign fault_reset = fsel_r[`SSS_FSEL_RESET] && cmd.ramp2;
	assign ramp2_active = !fsel_r[`SSS_FSEL_RESET] && cmd.ramp2;
	assign start_ok    = (flc_r != `SSS_FLC_RST) && !lockout && line_power;
	assign run_req     = cmd.run && !cmd.stop;

	// ----------------------------------------------------------------
	// phase loss detection
	// ----------------------------------------------------------------
	// compare current against 20 percent of full load
	assign cur_scaled  = {16'h0000, phase_a_current} * 32'(`SSS_PCT_FULL);
	assign lim_scaled  = {16'h0000, flc_r} * 32'(`SSS_PL_PCT);
	assign low_current = cur_scaled < lim_scaled;

	// the counter saturates at the trip count so the fault cannot wrap away;
	// leaving run or raising the current starts the count over
	// count time spent running at low current
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			pl_cnt_r <= '0;
		end else if ((state_r == sss_pkg::SSS_RUN) && low_current && ctrl_r[`SSS_CTRL_PLEN]) begin
			if (pl_cnt_r < 32'(PL_CYCLES)) begin
				pl_cnt_r <= pl_cnt_r + 32'h1;
			end
		end else begin
			pl_cnt_r <= '0;
		end
	end
	assign pl_trip = (pl_cnt_r == 32'(PL_CYCLES));

	// ----------------------------------------------------------------
	// run sequence
	// ----------------------------------------------------------------
	// idle waits for an accepted run request; accel waits for the speed flag;
	// run leaves on a stop, a refused start condition or a phase-loss trip;
	// decel holds the output until the current falls to the stop level;
	// fault holds until a reset through the second-ramp input
	// next state of the starter
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			sss_pkg::SSS_IDLE: begin
				if (run_req && start_ok) begin
					state_nxt = sss_pkg::SSS_ACCEL;
				end
			end
			sss_pkg::SSS_ACCEL: begin
				if (!run_req || !start_ok) begin
					state_nxt = sss_pkg::SSS_IDLE;
				end else if (full_speed) begin
					state_nxt = sss_pkg::SSS_RUN;
				end
			end
			sss_pkg::SSS_RUN: begin
				if (pl_trip) begin
					state_nxt = sss_pkg::SSS_FAULT;
				end else if (!run_req || !start_ok) begin
					if (ctrl_r[`SSS_CTRL_SSTOP]) begin
						state_nxt = sss_pkg::SSS_DECEL;
					end else begin
						state_nxt = sss_pkg::SSS_IDLE;
					end
				end
			end
			sss_pkg::SSS_DECEL: begin
				if (phase_a_current <= stoplvl_r) begin
					state_nxt = sss_pkg::SSS_IDLE;
				end
			end
			sss_pkg::SSS_FAULT: begin
				if (fault_reset) begin
					state_nxt = sss_pkg::SSS_IDLE;
				end
			end
			default: begin
				state_nxt = sss_pkg::SSS_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			state_r   <= sss_pkg::SSS_IDLE;
			state_d_r <= sss_pkg::SSS_IDLE;
		end else begin
			state_r   <= state_nxt;
			state_d_r <= state_r;
		end
	end

	// ----------------------------------------------------------------
	// indicators and display
	// ----------------------------------------------------------------
	// registered outputs from the state
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			ind     <= '0;
			display <= `SSS_DISP_IDLE;
		end else begin
			ind.power_on  <= 1'b1;
			ind.at_speed  <= (state_nxt == sss_pkg::SSS_RUN);
			ind.bypass    <= (state_nxt == sss_pkg::SSS_RUN);
			ind.output_on <= (state_nxt == sss_pkg::SSS_ACCEL) ||
			                 (state_nxt == sss_pkg::SSS_RUN) ||
			                 (state_nxt == sss_pkg::SSS_DECEL);
			ind.fault     <= (state_nxt == sss_pkg::SSS_FAULT);
			// idle reads zero current
			display <= (state_nxt == sss_pkg::SSS_IDLE) ? `SSS_DISP_IDLE :
			           phase_a_current;
		end
	end

	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------
	// start, at speed, stopped, fault
	assign irq_ev = {
		(state_r == sss_pkg::SSS_FAULT) && (state_d_r != sss_pkg::SSS_FAULT),
		(state_r == sss_pkg::SSS_IDLE) && (state_d_r != sss_pkg::SSS_IDLE),
		(state_r == sss_pkg::SSS_RUN) && (state_d_r == sss_pkg::SSS_ACCEL),
		(state_r == sss_pkg::SSS_ACCEL) && (state_d_r == sss_pkg::SSS_IDLE)
	};

	// bit 0 start, bit 1 at speed, bit 2 back to idle, bit 3 fault;
	// a read of the interrupt status word takes the old bits and keeps a new event
	// sticky bits, set wins over the clear by read
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			irq_stat_r <= '0;
		end else if (rd && (addr == `SSS_A_IRQ_STAT)) begin
			irq_stat_r <= irq_ev;
		end else begin
			irq_stat_r <= irq_stat_r | irq_ev;
		end
	end
	assign irq = |(irq_stat_r & irq_mask_r);

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	// word map of the register port:
	//   0 control: bit 0 soft stop, bit 1 phase-loss check, bit 2 spare
	//   1 input function select, 0 to 7
	//   2 motor full-load current; zero blocks every start
	//   3 ramp profile select
	//   4 first ramp duration in seconds
	//   5 start current limit in percent of full-load current
	//   6 status, read only
	//   7 interrupt status, cleared by its read
	//   8 interrupt mask
	//   9 phase A current, read only
	//   a display word, read only
	//   b soft stop level in current units
	// the ramp and limit words are held for the firing logic downstream;
	// unmapped words take no write and read as zero
	// settings with documented defaults
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			fsel_r     <= `SSS_FSEL_RST;
			flc_r      <= `SSS_FLC_RST;
			prof_r     <= `SSS_PROF_RST;
			ramp_r     <= `SSS_RAMP_RST;
			clim_r     <= `SSS_CLIM_RST;
			stoplvl_r  <= `SSS_STOPLVL_RST;
			ctrl_r     <= `SSS_CTRL_RST;
			irq_mask_r <= '0;
		end else if (wr) begin
			case (addr)
				`SSS_A_CTRL:     ctrl_r     <= wdata[2:0];
				`SSS_A_FSEL:     fsel_r     <= wdata[2:0];
				`SSS_A_FLC:      flc_r      <= wdata;
				`SSS_A_PROF:     prof_r     <= wdata[3:0];
				`SSS_A_RAMP:     ramp_r     <= wdata[7:0];
				`SSS_A_CLIM:     clim_r     <= wdata[11:0];
				`SSS_A_IRQ_MASK: irq_mask_r <= wdata[`SSS_IRQ_W-1:0];
				`SSS_A_STOPLVL:  stoplvl_r  <= wdata;
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// register reads
	// ----------------------------------------------------------------
	// status word: bit 7 ramp two in effect, bit 6 lockout, bit 5 remote,
	// bits 2 to 0 the sequencer state in declaration order
	// read data one cycle after the strobe, zero otherwise
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			rdata <= '0;
		end else if (rd) begin
			case (addr)
				`SSS_A_CTRL:     rdata <= {13'h0000, ctrl_r};
				`SSS_A_FSEL:     rdata <= {13'h0000, fsel_r};
				`SSS_A_FLC:      rdata <= flc_r;
				`SSS_A_PROF:     rdata <= {12'h000, prof_r};
				`SSS_A_RAMP:     rdata <= {8'h00, ramp_r};
				`SSS_A_CLIM:     rdata <= {4'h0, clim_r};
				`SSS_A_STATUS:   rdata <= {8'h00, ramp2_active, lockout, is_remote,
				                           2'h0, 3'(state_r)};
				`SSS_A_IRQ_STAT: rdata <= {12'h000, irq_stat_r};
				`SSS_A_IRQ_MASK: rdata <= {12'h000, irq_mask_r};
				`SSS_A_CURRENT:  rdata <= phase_a_current;
				`SSS_A_DISPLAY:  rdata <= display;
				`SSS_A_STOPLVL:  rdata <= stoplvl_r;
				default:         rdata <= '0;
			endcase
		end else begin
			rdata <= '0;
		end
	end
endmodule

// ---- sss_checker.sv ----
`timescale 1ns/10ps
module sss_checker #(
	parameter int PL_CYCLES = 20
) (
	// clock, reset and bus
	input wire logic              mclk,
	input wire logic              nrst,
	input wire logic [3:0]        addr,
	input wire logic [15:0]       wdata,
	input wire logic              wr,
	// plant inputs and outputs
	input wire logic [15:0]       phase_a_current,
	input wire logic              full_speed,
	input wire logic              line_power,
	input wire sss_pkg::sss_ind_t ind,
	input wire logic              ramp2_active,
	input wire logic [15:0]       display
);
	logic [15:0] flc_r;
	logic [2:0]  fsel_r;
	int          low_r;
	// ----------------------------------------------------------------
	// shadow state
	// ----------------------------------------------------------------
	// settings as written over the bus
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			flc_r  <= 16'h0000;
			fsel_r <= 3'h7;
		end else if (wr && addr == 4'h2) begin
			flc_r <= wdata;
		end else if (wr && addr == 4'h1) begin
			fsel_r <= wdata[2:0];
		end
	end
	// cycles spent at speed below the phase-loss threshold
	always_ff @(posedge mclk) begin
		if (!nrst || !ind.at_speed || 32'(phase_a_current) * 100 >= 32'(flc_r) * 20) begin
			low_r <= 0;
		end else begin
			low_r <= low_r + 1;
		end
	end
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_power_on_lit: assert property (@(posedge mclk) disable iff (!nrst)
		$past(nrst) |-> ind.power_on) else $error("power-on indicator dark");
	a_idle_display: assert property (@(posedge mclk) disable iff (!nrst)
		!ind.output_on && !ind.fault |-> display == 16'h0000) else $error("idle display");
	a_bypass_speed: assert property (@(posedge mclk) disable iff (!nrst)
		ind.bypass == ind.at_speed) else $error("bypass and at-speed differ");
	a_speed_reached: assert property (@(posedge mclk) disable iff (!nrst)
		$rose(ind.at_speed) |-> $past(full_speed)) else $error("at-speed without full speed");
	a_start_gated: assert property (@(posedge mclk) disable iff (!nrst)
		$rose(ind.output_on) |-> $past(flc_r) != 16'h0000 && $past(line_power))
		else $error("start while refused");
	a_ramp2_gate: assert property (@(posedge mclk) disable iff (!nrst)
		ramp2_active |-> fsel_r < 3'h4) else $error("ramp two under reset select");
	a_trip_delay: assert property (@(posedge mclk) disable iff (!nrst)
		$rose(ind.fault) |-> $past(low_r) >= PL_CYCLES - 3) else $error("early phase-loss trip");
	a_stop_order: assert property (@(posedge mclk) disable iff (!nrst)
		$fell(ind.at_speed) |-> !ind.bypass) else $error("bypass held after at-speed off");
endmodule

bind sss_sequencer sss_checker #(.PL_CYCLES(PL_CYCLES)) sss_checker_inst (.mclk, .nrst,
	.addr, .wdata, .wr, .phase_a_current, .full_speed, .line_power, .ind, .ramp2_active,
	.display);

// ---- sss_operator.sv ----
`timescale 1ns/10ps
module sss_operator (
	// clock
	input wire logic              mclk,
	// contact states asked for
	input wire sss_pkg::sss_cmd_t term_want,
	input wire sss_pkg::sss_cmd_t comm_want,
	// strip and adapter levels
	output sss_pkg::sss_cmd_t     term_cmd,
	output sss_pkg::sss_cmd_t     comm_cmd
);
	// contacts move just after an edge; adapter levels are synchronous
	always_ff @(posedge mclk) begin
		term_cmd <= term_want;
		comm_cmd <= comm_want;
	end
endmodule

// ---- soft_start_run_sequencer_tb_top.sv ----
`timescale 1ns/10ps
module soft_start_run_sequencer_tb_top;
	localparam int PL = 20;
	localparam logic [3:0]  RA [7] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hb, 4'hf};
	localparam logic [15:0] RV [7] = '{16'h7, 16'h0, 16'h1, 16'ha, 16'h15e, 16'h0, 16'h0};
	logic              mclk, nrst, wr, rd, fs, lp, r2a, irq;
	logic [3:0]        addr;
	logic [15:0]       wdata, rdata, cur, disp, flc;
	sss_pkg::sss_cmd_t tw, cw, term_cmd, comm_cmd;
	sss_pkg::sss_ind_t ind;
	integer            seed, bad_count, n_checks;
	// clock
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	sss_operator sss_operator_inst (.mclk(mclk), .term_want(tw), .comm_want(cw),
		.term_cmd(term_cmd), .comm_cmd(comm_cmd));
	sss_sequencer #(.PL_CYCLES(PL)) sss_sequencer_inst (.mclk(mclk), .nrst(nrst),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .term_cmd(term_cmd),
		.comm_cmd(comm_cmd), .phase_a_current(cur), .full_speed(fs), .line_power(lp),
		.ind(ind), .ramp2_active(r2a), .display(disp), .irq(irq));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic r2exp(input logic [2:0] f, input logic r);
		return f < 3'h4 && r;
	endfunction
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_checks = n_checks + 1;
		if (g !== e) begin
			bad_count = bad_count + 1;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wreg(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	task automatic rchk(input logic [3:0] a, input logic [15:0] e);
		@(posedge mclk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 chk(rdata, e);
	endtask
	// bounded wait on output_on (0), at_speed (1) or fault (2)
	task automatic wait_on(input int s, input logic v);
		logic x;
		for (int i = 0; i < 100; i++) begin
			@(posedge mclk);
			#1 x = (s == 0) ? ind.output_on : (s == 1) ? ind.at_speed : ind.fault;
			if (x === v) return;
		end
		chk(16'(x), 16'(v));
		summarize();
	endtask
	task automatic refused();
		tw.run <= 1'b1;
		repeat (8) @(posedge mclk);
		#1 chk(16'(ind.output_on), 16'h0);
		tw.run <= 1'b0;
		repeat (4) @(posedge mclk);
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		seed = 3;
		bad_count = 0;
		n_checks = 0;
		{nrst, wr, rd, addr, wdata, tw, cw, cur, fs, lp} = '0;
		lp = 1'b1;
		repeat (5) @(posedge mclk);
		nrst <= 1'b1;
		repeat (2) @(posedge mclk);
		#1 chk(16'(ind.power_on), 16'h1);
		chk(disp, 16'h0000);
		for (int i = 0; i < 7; i++) rchk(RA[i], RV[i]);
		refused();
		flc = 16'h0100 + 16'($random(seed) & 32'h3fff);
		cur <= flc + 16'($random(seed) & 32'h00ff);
		wreg(4'h2, flc);
		wreg(4'h0, 16'h0003);
		wreg(4'h8, 16'h000f);
		wreg(4'hb, 16'h0010);
		// meaning of the second-ramp input for every select
		for (int f = 0; f < 8; f++) begin
			wreg(4'h1, 16'(f));
			tw.ramp2 <= 1'b1;
			repeat (4) @(posedge mclk);
			#1 chk(16'(r2a), 16'(r2exp(3'(f), 1'b1)));
			tw.ramp2 <= 1'b0;
			repeat (4) @(posedge mclk);
			#1 chk(16'(r2a), 16'h0);
		end
		// start, at speed, soft stop
		wreg(4'h1, 16'h0000);
		tw.run <= 1'b1;
		wait_on(0, 1'b1);
		fs <= 1'b1;
		wait_on(1, 1'b1);
		chk(16'(ind.bypass), 16'h1);
		tw.run <= 1'b0;
		wait_on(1, 1'b0);
		chk(16'(ind.bypass), 16'h0);
		chk(16'(ind.output_on), 16'h1);
		cur <= 16'h0008;
		fs  <= 1'b0;
		wait_on(0, 1'b0);
		chk(disp, 16'h0000);
		chk(16'(irq), 16'h1);
		rchk(4'h7, 16'h0007);
		#1 chk(16'(irq), 16'h0);
		// stop button during a soft-stop run
		cur    <= flc;
		tw.run <= 1'b1;
		wait_on(0, 1'b1);
		fs <= 1'b1;
		wait_on(1, 1'b1);
		chk(disp, flc);
		tw.stop <= 1'b1;
		wait_on(1, 1'b0);
		chk(16'(ind.bypass), 16'h0);
		chk(16'(ind.output_on), 16'h1);
		tw.run  <= 1'b0;
		tw.stop <= 1'b0;
		cur     <= 16'h0000;
		fs      <= 1'b0;
		wait_on(0, 1'b0);
		// remote and local command sources
		wreg(4'h0, 16'h0002);
		wreg(4'h1, 16'h0001);
		tw.jog <= 1'b1;
		refused();
		rchk(4'h6, 16'h0020);
		cw.run <= 1'b1;
		wait_on(0, 1'b1);
		cw.run <= 1'b0;
		wait_on(0, 1'b0);
		tw.jog <= 1'b0;
		tw.run <= 1'b1;
		wait_on(0, 1'b1);
		tw.run <= 1'b0;
		wait_on(0, 1'b0);
		// lockouts and missing line power
		wreg(4'h1, 16'h0002);
		tw.jog <= 1'b1;
		refused();
		rchk(4'h6, 16'h0040);
		wreg(4'h1, 16'h0003);
		tw.jog <= 1'b0;
		refused();
		wreg(4'h1, 16'h0004);
		lp <= 1'b0;
		refused();
		lp <= 1'b1;
		// running phase-loss trip, masked then unmasked interrupt
		wreg(4'h8, 16'h0000);
		cur <= flc;
		tw.run <= 1'b1;
		wait_on(0, 1'b1);
		fs <= 1'b1;
		wait_on(1, 1'b1);
		cur <= flc / 8;
		repeat (PL - 4) @(posedge mclk);
		#1 chk(16'(ind.fault), 16'h0);
		wait_on(2, 1'b1);
		chk(16'(irq), 16'h0);
		wreg(4'h8, 16'h0008);
		#1 chk(16'(irq), 16'h1);
		rchk(4'h7, 16'h000f);
		#1 chk(16'(irq), 16'h0);
		rchk(4'h6, 16'h0004);
		tw.run   <= 1'b0;
		fs       <= 1'b0;
		tw.ramp2 <= 1'b1;
		wait_on(2, 1'b0);
		summarize();
	end
endmodule
